// >>> core/zcdg_pkg.sv
// package of constants for the zero cross drive gating block
package zcdg_pkg;

  // ************************************************************
  // clock and open-loop pulse timing
  // ************************************************************
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned NS_PER_SEC  = 1_000_000_000;
  localparam int unsigned CLK_NS      = NS_PER_SEC / CLK_HZ;
  localparam int unsigned OL_PULSES   = 4;
  localparam int unsigned OL_OFF_MULT = 3;
  // on-times in microseconds, first to fourth pulse
  localparam int unsigned OL_TON1_US  = 1;
  localparam int unsigned OL_TON2_US  = 2;
  localparam int unsigned OL_TON3_US  = 4;
  localparam int unsigned OL_TON4_US  = 6;
  localparam int unsigned OL_TON1_CYC = OL_TON1_US * 1000 / CLK_NS;
  localparam int unsigned OL_TON2_CYC = OL_TON2_US * 1000 / CLK_NS;
  localparam int unsigned OL_TON3_CYC = OL_TON3_US * 1000 / CLK_NS;
  localparam int unsigned OL_TON4_CYC = OL_TON4_US * 1000 / CLK_NS;
  localparam int unsigned OL_CNT_W    = 10;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic GATE_RST = 1'b0;
  localparam logic DRV_RST  = 1'b0;

  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ZCDG_IDLE = 2'b00,
    ZCDG_ON   = 2'b01,
    ZCDG_OFF  = 2'b10
  } zcdg_state_t;

endpackage

// >>> core/zcdg_gate.sv
// hysteresis gate for one drive class
`timescale 1ns/1ps
module zcdg_gate (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_above_start,
  input  wire logic i_below_stop,
  input  wire logic i_hold_off,
  output logic      o_enable
);
  import zcdg_pkg::*;

  logic enable_reg;

  // hold state between the levels so sense noise cannot chatter the drive
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_reg <= GATE_RST;
    end else if (i_hold_off || i_below_stop) begin
      enable_reg <= 1'b0;
    end else if (i_above_start) begin
      enable_reg <= 1'b1;
    end
  end

  assign o_enable = enable_reg;
endmodule

// >>> core/zcdg_top.sv
// zero cross drive gating and open-loop pulse sequencer
`timescale 1ns/1ps
module zcdg_top #(
  parameter int unsigned CNT_W = zcdg_pkg::OL_CNT_W
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_polarity,
  input  wire logic i_primary_above_start,
  input  wire logic i_primary_below_stop,
  input  wire logic i_sync_above_start,
  input  wire logic i_sync_below_stop,
  input  wire logic i_slow_above_start,
  input  wire logic i_slow_below_stop,
  input  wire logic i_duty_pwm,
  output logic      o_fast_leg_low_drive,
  output logic      o_fast_leg_high_drive,
  output logic      o_sync_low_drive,
  output logic      o_sync_high_drive,
  output logic      o_slow_low_drive,
  output logic      o_slow_high_drive,
  output logic      o_sense_blank,
  output logic      o_open_loop_active
);
  import zcdg_pkg::*;

  // ************************************************************
  // polarity edge detect
  // ************************************************************
  logic        pol_reg;
  logic        pol_valid_reg;
  logic        pol_rise;
  logic        pol_fall;

  // first sample after reset only seeds the history, it is no edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pol_reg       <= 1'b0;
      pol_valid_reg <= 1'b0;
    end else begin
      pol_reg       <= i_polarity;
      pol_valid_reg <= 1'b1;
    end
  end

  assign pol_rise = pol_valid_reg && i_polarity && !pol_reg;
  assign pol_fall = pol_valid_reg && !i_polarity && pol_reg;

  // ************************************************************
  // open-loop pulse sequencer
  // ************************************************************
  zcdg_state_t      state_reg;
  logic [1:0]       pulse_idx_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             to_low_reg;
  logic [CNT_W-1:0] ton_cyc;
  logic [CNT_W-1:0] toff_cyc;
  logic             pol_edge;
  logic             on_done;
  logic             off_done;
  logic             last_pulse;
  logic             ol_busy;

  assign pol_edge = pol_rise || pol_fall;

  // on-time lookup, counts derived from the core clock
  always_comb begin
    case (pulse_idx_reg)
      2'h0:    ton_cyc = CNT_W'(OL_TON1_CYC);
      2'h1:    ton_cyc = CNT_W'(OL_TON2_CYC);
      2'h2:    ton_cyc = CNT_W'(OL_TON3_CYC);
      default: ton_cyc = CNT_W'(OL_TON4_CYC);
    endcase
  end

  // fixed off to on ratio keeps the duty equal over all pulses
  assign toff_cyc   = CNT_W'(OL_OFF_MULT * ton_cyc);
  assign on_done    = (cnt_reg >= ton_cyc);
  assign off_done   = (cnt_reg >= toff_cyc);
  assign last_pulse = (pulse_idx_reg == 2'(OL_PULSES - 1));

  // a new edge restarts the sequence, even mid-sequence
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ZCDG_IDLE;
    end else if (pol_edge) begin
      state_reg <= ZCDG_ON;
    end else begin
      case (state_reg)
        ZCDG_IDLE: begin
          state_reg <= ZCDG_IDLE;
        end
        ZCDG_ON: begin
          if (on_done) begin
            state_reg <= ZCDG_OFF;
          end
        end
        ZCDG_OFF: begin
          if (off_done && last_pulse) begin
            state_reg <= ZCDG_IDLE;
          end else if (off_done) begin
            state_reg <= ZCDG_ON;
          end
        end
        default: begin
          state_reg <= ZCDG_IDLE;
        end
      endcase
    end
  end

  // pulse index only advances as an off-time ends
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_idx_reg <= 2'h0;
    end else if (pol_edge) begin
      pulse_idx_reg <= 2'h0;
    end else if (state_reg == ZCDG_OFF && off_done && !last_pulse) begin
      pulse_idx_reg <= pulse_idx_reg + 2'h1;
    end
  end

  // count starts at one, so a phase of n cycles ends as it reaches n
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else if (pol_edge) begin
      cnt_reg <= CNT_W'(1);
    end else if (state_reg == ZCDG_IDLE) begin
      cnt_reg <= '0;
    end else if ((state_reg == ZCDG_ON && on_done) || (state_reg == ZCDG_OFF && off_done)) begin
      cnt_reg <= CNT_W'(1);
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  // low fast switch on entry to a positive half, high on a negative one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      to_low_reg <= 1'b0;
    end else if (pol_edge) begin
      to_low_reg <= pol_rise;
    end
  end

  assign ol_busy = (state_reg != ZCDG_IDLE);

  // ************************************************************
  // class gates
  // ************************************************************
  logic primary_en;
  logic sync_en;
  logic slow_en;

  // same comparator flags serve both half cycles: magnitude is rectified
  zcdg_gate u_primary_gate (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_above_start (i_primary_above_start),
    .i_below_stop  (i_primary_below_stop),
    .i_hold_off    (ol_busy),
    .o_enable      (primary_en)
  );

  zcdg_gate u_sync_gate (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_above_start (i_sync_above_start),
    .i_below_stop  (i_sync_below_stop),
    .i_hold_off    (ol_busy),
    .o_enable      (sync_en)
  );

  // held off during pulses; re-enables on its own level afterwards
  zcdg_gate u_slow_gate (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_above_start (i_slow_above_start),
    .i_below_stop  (i_slow_below_stop),
    .i_hold_off    (ol_busy),
    .o_enable      (slow_en)
  );

  // ************************************************************
  // slow-leg once-per-half lock
  // ************************************************************
  logic slow_seen_reg;
  logic slow_spent_reg;

  // re-arming within a half would let sense noise switch the slow leg twice
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_seen_reg <= 1'b0;
    end else if (pol_edge) begin
      slow_seen_reg <= 1'b0;
    end else if (slow_en && !ol_busy) begin
      slow_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_spent_reg <= 1'b0;
    end else if (pol_edge) begin
      slow_spent_reg <= 1'b0;
    end else if (slow_seen_reg && !slow_en) begin
      slow_spent_reg <= 1'b1;
    end
  end

  // ************************************************************
  // drive steering, all outputs registered
  // ************************************************************
  logic ol_pulse;
  logic duty_on;
  logic sync_on;
  logic slow_on;

  assign ol_pulse = (state_reg == ZCDG_ON);
  assign duty_on  = primary_en && i_duty_pwm;
  assign sync_on  = sync_en && primary_en && !i_duty_pwm;
  assign slow_on  = slow_en && !slow_spent_reg;

  // positive half: low fast switch is duty-controlled, high is sync
  // fast leg: open-loop pulses replace the duty command while they run
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fast_leg_low_drive  <= DRV_RST;
      o_fast_leg_high_drive <= DRV_RST;
    end else if (ol_busy) begin
      o_fast_leg_low_drive  <= ol_pulse && to_low_reg;
      o_fast_leg_high_drive <= ol_pulse && !to_low_reg;
    end else begin
      o_fast_leg_low_drive  <= pol_reg && duty_on;
      o_fast_leg_high_drive <= !pol_reg && duty_on;
    end
  end

  // sync drive sits on the switch opposite the duty switch
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sync_low_drive  <= DRV_RST;
      o_sync_high_drive <= DRV_RST;
    end else if (ol_busy) begin
      o_sync_low_drive  <= 1'b0;
      o_sync_high_drive <= 1'b0;
    end else begin
      o_sync_high_drive <= pol_reg && sync_on;
      o_sync_low_drive  <= !pol_reg && sync_on;
    end
  end

  // slow leg: low switch conducts through a positive half
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_slow_low_drive  <= DRV_RST;
      o_slow_high_drive <= DRV_RST;
    end else if (ol_busy) begin
      o_slow_low_drive  <= 1'b0;
      o_slow_high_drive <= 1'b0;
    end else begin
      o_slow_low_drive  <= pol_reg && slow_on;
      o_slow_high_drive <= !pol_reg && slow_on;
    end
  end

  // blank covers the whole sequence, off-times included
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sense_blank <= 1'b0;
    end else begin
      o_sense_blank <= ol_busy;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_open_loop_active <= 1'b0;
    end else begin
      o_open_loop_active <= ol_busy;
    end
  end
endmodule

// >>> dv/zcdg_drv_model.sv
// gate driver model that latches shoot-through of the fast or the slow drive pair; the sync drives are not taken in
`timescale 1ns/1ps
module zcdg_drv_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_fast_low,
  input  wire logic i_fast_high,
  input  wire logic i_slow_low,
  input  wire logic i_slow_high,
  output logic      o_shoot
);
  // ****
  // sticky: a real bridge would not survive it
  // ****
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_shoot <= 1'b0;
    end else if ((i_fast_low && i_fast_high) || (i_slow_low && i_slow_high)) begin
      o_shoot <= 1'b1;
    end
  end
endmodule

// >>> dv/zcdg_checker.sv
// port assertions for the zero cross drive gating top
`timescale 1ns/1ps
module zcdg_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_polarity,
  input logic      o_fast_leg_low_drive,
  input logic      o_fast_leg_high_drive,
  input logic      o_sync_low_drive,
  input logic      o_sync_high_drive,
  input logic      o_slow_low_drive,
  input logic      o_slow_high_drive,
  input logic      o_sense_blank,
  input logic      o_open_loop_active
);
  // ****
  // assertions
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_blank_twin: assert property (o_sense_blank == o_open_loop_active)
    else $error("blank and open-loop flag differ");
  chk_slow_held: assert property (o_sense_blank |-> !(o_slow_low_drive || o_slow_high_drive))
    else $error("slow drive during open-loop pulses");
  chk_sync_held: assert property (o_sense_blank |-> !(o_sync_low_drive || o_sync_high_drive))
    else $error("sync drive during open-loop pulses");
  chk_fast_excl: assert property (!(o_fast_leg_low_drive && o_fast_leg_high_drive))
    else $error("both fast drives high");
  chk_slow_excl: assert property (!(o_slow_low_drive && o_slow_high_drive))
    else $error("both slow drives high");
  chk_sync_compl: assert property (!(o_sync_high_drive && o_fast_leg_low_drive)
    && !(o_sync_low_drive && o_fast_leg_high_drive)) else $error("sync overlaps duty drive");
  // first clock after release only seeds the polarity history
  chk_ol_start: assert property ($changed(i_polarity) && $past(i_rst_n) |-> ##[1:3] o_sense_blank)
    else $error("no open-loop start after polarity edge");
  chk_first_pulse: assert property ($rose(o_sense_blank) |->
    (o_fast_leg_low_drive ^ o_fast_leg_high_drive) [*8]) else $error("first pulse too short");
endmodule
bind zcdg_top zcdg_checker chk (.*);

// >>> dv/testbench.sv
// self-checking bench for the zero cross drive gating block
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] %s exp %0d got %0d", n, e, a); end end
module testbench;
  import zcdg_pkg::*;
  // ****
  // stimulus, drives seen, model gate states
  // ****
  logic       i_clk = 0, i_rst_n = 0, pol = 0, duty = 0;
  logic [5:0] flg = 6'h00;
  logic       fl, fh, yl, yh, sl, sh, bl, ol, shoot;
  int         fails = 0, num_checks = 0, pen = 0, yen = 0, len = 0, sdn = 0;
  int         hi_q[$], lo_q[$];
  int         us[4] = '{1, 2, 4, 6};
  logic [5:0] fs[5] = '{6'h2a, 6'h00, 6'h04, 6'h01, 6'h10};
  always #12.5 i_clk = ~i_clk;
  zcdg_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_polarity(pol), .i_primary_above_start(flg[5]),
    .i_primary_below_stop(flg[4]), .i_sync_above_start(flg[3]), .i_sync_below_stop(flg[2]),
    .i_slow_above_start(flg[1]), .i_slow_below_stop(flg[0]), .i_duty_pwm(duty),
    .o_fast_leg_low_drive(fl), .o_fast_leg_high_drive(fh), .o_sync_low_drive(yl),
    .o_sync_high_drive(yh), .o_slow_low_drive(sl), .o_slow_high_drive(sh), .o_sense_blank(bl),
    .o_open_loop_active(ol));
  zcdg_drv_model drv (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_fast_low(fl), .i_fast_high(fh),
    .i_slow_low(sl), .i_slow_high(sh), .o_shoot(shoot));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // flags rise mid-sequence to prove they are ignored until it ends
  task automatic ol_seq(input logic p);
    int k, run;
    logic prev;
    hi_q = {};
    lo_q = {};
    run = 0;
    prev = 1;
    @(posedge i_clk);
    pol <= p;
    fork begin repeat (6) @(posedge i_clk); flg <= 6'h2a; end join_none
    for (k = 0; k < 40 && bl !== 1; k++) @(negedge i_clk);
    `CHK("blank rise", 1, bl)
    for (k = 0; k < 3000 && bl === 1; k++) begin
      `CHK("held drives", 0, {yl, yh, sl, sh, ol ^ bl, p ? fh : fl})
      if ((p ? fl : fh) !== prev) begin
        if (prev) hi_q.push_back(run);
        else lo_q.push_back(run);
        run = 0;
      end
      prev = p ? fl : fh;
      run++;
      @(negedge i_clk);
    end
    if (k >= 3000) begin fails++; wrap_up(); end
    `CHK("pulse count", 4, hi_q.size())
    for (k = 0; k < 4; k++) begin
      `CHK("on time", us[k] * 40, hi_q[k])
      if (k < 3) `CHK("off time", us[k] * 120, lo_q[k])
    end
    pen = 0;
    yen = 0;
    len = 0;
    sdn = 0;
  endtask
  task automatic steady(input logic [5:0] f);
    logic d;
    @(posedge i_clk);
    flg <= f;
    pen = f[4] ? 0 : f[5] ? 1 : pen;
    yen = f[2] ? 0 : f[3] ? 1 : yen;
    if (f[0] && len) sdn = 1;
    len = f[0] ? 0 : f[1] && !sdn ? 1 : len;
    repeat (6) begin
      d = 1'($urandom);
      @(posedge i_clk);
      duty <= d;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      `CHK("duty drive", d & pen[0], pol ? fl : fh)
      `CHK("sync drive", !d & yen[0] & pen[0], pol ? yh : yl)
      `CHK("slow drive", len[0], pol ? sl : sh)
      `CHK("other side", 3'h0, pol ? {fh, yl, sh} : {fl, yh, sl})
    end
  endtask
  // reset lands mid-sequence with polarity high: a bad edge seed would restart it
  task automatic mid_reset();
    int k;
    @(posedge i_clk);
    pol <= 1;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    `CHK("reset mid run", 8'h00, {fl, fh, yl, yh, sl, sh, bl, ol})
    @(posedge i_clk);
    i_rst_n <= 1;
    for (k = 0; k < 40; k++) begin
      @(negedge i_clk);
      `CHK("idle after reset", 0, bl)
    end
  endtask
  initial begin
    void'($urandom(32'h5f8b));
    repeat (12) @(posedge i_clk);
    `CHK("reset drives", 8'h00, {fl, fh, yl, yh, sl, sh, bl, ol})
    i_rst_n <= 1;
    ol_seq(1);
    foreach (fs[i]) steady(fs[i]);
    steady(6'h02);
    ol_seq(0);
    steady(6'h2a);
    steady(6'h10);
    `CHK("shoot through", 0, shoot)
    mid_reset();
    ol_seq(0);
    `CHK("shoot after reset", 0, shoot)
    wrap_up();
  end
endmodule
